/* logic/bridge_led_pkg.sv */
package bridge_led_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_MHZ           = 250;   // Core clock rate
  localparam int CLK_PERIOD_NS     = 4;     // Core clock period
  localparam int RESET_MIN_MS      = 1;     // Least board reset hold after supplies are good
  localparam int RESET_MIN_CYCLES  = RESET_MIN_MS * CLK_MHZ * 1000;
  localparam int HEARTBEAT_HALF_MS = 250;   // Half period of the heartbeat blink
  localparam int HEARTBEAT_HALF_CYCLES_DEF = HEARTBEAT_HALF_MS * CLK_MHZ * 1000;
  localparam int FADE_STEP_NS      = 4000;  // Time per brightness step
  localparam int FADE_STEP_CYCLES  = (FADE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Pulse-width settings
  localparam int         PWM_WIDTH        = 8;
  localparam logic [7:0] DUTY_OFF         = 8'h00;
  localparam logic [7:0] FADE_MAX         = 8'hFF;
  localparam logic [7:0] DISK_ACTIVE_DUTY = 8'hC0;

  ////////////////////////////////////////////////////////////////////////////
  // Link state input encoding (core side)
  localparam logic [1:0] LINK_U0 = 2'h0;
  localparam logic [1:0] LINK_U1 = 2'h1;
  localparam logic [1:0] LINK_U2 = 2'h2;
  localparam logic [1:0] LINK_U3 = 2'h3;

  // Two-pin power state code driven to the board
  localparam logic [1:0] PSC_U3 = 2'h0;     // Also the value after reset
  localparam logic [1:0] PSC_U2 = 2'h1;
  localparam logic [1:0] PSC_U1 = 2'h2;
  localparam logic [1:0] PSC_U0 = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Reference clock strap decode
  localparam logic [1:0] STRAP_20 = 2'h0;
  localparam logic [1:0] STRAP_25 = 2'h1;
  localparam logic [1:0] STRAP_30 = 2'h2;
  localparam logic [1:0] STRAP_40 = 2'h3;
  localparam logic [5:0] FREQ_20_MHZ = 6'h14;
  localparam logic [5:0] FREQ_25_MHZ = 6'h19;
  localparam logic [5:0] FREQ_30_MHZ = 6'h1E;
  localparam logic [5:0] FREQ_40_MHZ = 6'h28;

  ////////////////////////////////////////////////////////////////////////////
  // Fade sequencer states
  typedef enum logic [1:0] {
    FADE_OFF  = 2'b00,
    FADE_UP   = 2'b01,
    FADE_DOWN = 2'b10
  } fade_state_t;

endpackage : bridge_led_pkg

/* logic/pwm_gen.sv */
`timescale 1ns/1ps
module pwm_gen (
  // Clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 rst,
  // Board reset: holds the period counter at its default
  input  wire logic                                 sync_clear,
  // Duty and output
  input  wire logic [bridge_led_pkg::PWM_WIDTH-1:0] duty,
  output logic                                      pwm_out
);
  import bridge_led_pkg::*;

  logic [PWM_WIDTH-1:0] cnt_reg;   // Free running period counter
  logic [PWM_WIDTH-1:0] cnt_next;
  logic                 out_reg;   // Registered output level
  logic                 out_next;

  ////////////////////////////////////////////////////////////////////////////
  // Next values: high while the counter is below the duty; the board
  // reset parks the counter too, so no register keeps running in reset
  always_comb begin
    cnt_next = cnt_reg + 1'b1;
    out_next = (cnt_reg < duty);
    if (sync_clear) begin
      cnt_next = '0;
      out_next = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign pwm_out = out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_pwm_zero_low: assert property (@(posedge sys_clk) disable iff (rst)
    (duty == DUTY_OFF) |=> !pwm_out) else $error("pwm high with zero duty");
  a_pwm_clear_count: assert property (@(posedge sys_clk) disable iff (rst)
    sync_clear |=> cnt_reg == '0 && !pwm_out) else $error("pwm counter not cleared");

endmodule : pwm_gen

/* logic/bridge_status_led_and_strap.sv */
`timescale 1ns/1ps
// Summary of operation
// - Each output carries one fixed indicator function
// - Power state code: U3 00 U2 01 U1 10 U0 11
// - Suspend indicator fades up and down continuously
// - Push button pin is only sampled
// - Reset returns all registers to defaults
// - During reset indicators show no activity
// - Strap selects 20, 25, 30 or 40 MHz
module bridge_status_led_and_strap #(
  parameter int HEARTBEAT_HALF_CYCLES = bridge_led_pkg::HEARTBEAT_HALF_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       global_reset_n,
  // Straps
  input  wire logic [1:0] ref_freq_strap,
  // Core status
  input  wire logic       fw_running,
  input  wire logic       storage_busy,
  input  wire logic       superspeed_connected,
  input  wire logic       legacy_connected,
  input  wire logic       legacy_suspend,
  input  wire logic [1:0] usb3_link_state,
  // Board push button
  input  wire logic       push_button_in,
  output logic            push_button_state,
  // Indicator outputs
  output logic            heartbeat_out,
  output logic [1:0]      link_power_state_code,
  output logic            legacy_suspend_out,
  output logic            legacy_connected_out,
  output logic            superspeed_connected_out,
  output logic            disk_activity_pwm,
  output logic            suspend_fade_pwm,
  // Clock multiplier select
  output logic [5:0]      ref_freq_mhz
);
  import bridge_led_pkg::*;

  logic [31:0]     hb_cnt_reg;      // Heartbeat half period counter
  logic [31:0]     hb_cnt_next;
  logic            hb_reg;          // Heartbeat level
  logic            hb_next;
  logic [1:0]      psc_reg;         // Power state code
  logic [1:0]      psc_next;
  logic            sus_reg;         // Legacy suspend indicator
  logic            sus_next;
  logic            lcon_reg;        // Legacy connected indicator
  logic            lcon_next;
  logic            scon_reg;        // SuperSpeed connected indicator
  logic            scon_next;
  logic            btn_reg;         // Sampled push button
  logic            btn_next;
  logic [5:0]      freq_reg;        // Decoded reference frequency
  logic [5:0]      freq_next;
  logic [7:0]      disk_duty_reg;   // Disk activity duty
  logic [7:0]      disk_duty_next;
  fade_state_t     fade_state_reg;  // Fade sequencer
  fade_state_t     fade_state_next;
  logic [7:0]      bright_reg;      // Fade brightness
  logic [7:0]      bright_next;
  logic [9:0]      step_reg;        // Cycles within one brightness step
  logic [9:0]      step_next;
  logic            suspend_cond;    // Any suspend that must fade the indicator

  // Fading runs only out of reset and while some suspend holds
  assign suspend_cond = global_reset_n &&
                        ((superspeed_connected && usb3_link_state == LINK_U3) ||
                         legacy_suspend);

  ////////////////////////////////////////////////////////////////////////////
  // Indicator next values; the board reset forces defaults so no
  // link activity leaks out while the device is nonfunctional
  always_comb begin
    hb_cnt_next    = hb_cnt_reg;
    hb_next        = hb_reg;
    psc_next       = PSC_U3;
    sus_next       = 1'b0;
    lcon_next      = 1'b0;
    scon_next      = 1'b0;
    btn_next       = 1'b0;
    disk_duty_next = DUTY_OFF;
    freq_next      = freq_reg;
    if (!global_reset_n) begin
      hb_cnt_next = '0;
      hb_next     = 1'b0;
      // Strap is caught while the board reset holds, then frozen
      case (ref_freq_strap)
        STRAP_20: freq_next = FREQ_20_MHZ;
        STRAP_25: freq_next = FREQ_25_MHZ;
        STRAP_30: freq_next = FREQ_30_MHZ;
        STRAP_40: freq_next = FREQ_40_MHZ;
        default:  freq_next = FREQ_20_MHZ;
      endcase
    end else begin
      // Heartbeat: stalls while firmware is not running
      if (fw_running) begin
        if (hb_cnt_reg == 32'(HEARTBEAT_HALF_CYCLES - 1)) begin
          hb_cnt_next = '0;
          hb_next     = ~hb_reg;
        end else begin
          hb_cnt_next = hb_cnt_reg + 32'h0000_0001;
        end
      end
      // Power state code only meaningful on a SuperSpeed link
      if (superspeed_connected) begin
        case (usb3_link_state)
          LINK_U0: psc_next = PSC_U0;
          LINK_U1: psc_next = PSC_U1;
          LINK_U2: psc_next = PSC_U2;
          LINK_U3: psc_next = PSC_U3;
          default: psc_next = PSC_U3;
        endcase
      end
      sus_next       = legacy_suspend;
      lcon_next      = legacy_connected;
      scon_next      = superspeed_connected;
      btn_next       = push_button_in;
      disk_duty_next = storage_busy ? DISK_ACTIVE_DUTY : DUTY_OFF;
    end
  end

  // Indicator registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hb_cnt_reg    <= '0;
      hb_reg        <= 1'b0;
      psc_reg       <= PSC_U3;
      sus_reg       <= 1'b0;
      lcon_reg      <= 1'b0;
      scon_reg      <= 1'b0;
      btn_reg       <= 1'b0;
      disk_duty_reg <= DUTY_OFF;
      freq_reg      <= FREQ_20_MHZ;
    end else begin
      hb_cnt_reg    <= hb_cnt_next;
      hb_reg        <= hb_next;
      psc_reg       <= psc_next;
      sus_reg       <= sus_next;
      lcon_reg      <= lcon_next;
      scon_reg      <= scon_next;
      btn_reg       <= btn_next;
      disk_duty_reg <= disk_duty_next;
      freq_reg      <= freq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fade sequencer: triangle ramp of brightness, one step per
  // step period; a full cycle is about two milliseconds
  always_comb begin
    fade_state_next = fade_state_reg;
    bright_next     = bright_reg;
    step_next       = step_reg;
    if (!suspend_cond) begin
      fade_state_next = FADE_OFF;
      bright_next     = DUTY_OFF;
      step_next       = '0;
    end else begin
      case (fade_state_reg)
        FADE_OFF: begin
          fade_state_next = FADE_UP;
          bright_next     = DUTY_OFF;
          step_next       = '0;
        end
        FADE_UP: begin
          if (step_reg == 10'(FADE_STEP_CYCLES - 1)) begin
            step_next = '0;
            if (bright_reg == FADE_MAX) begin
              fade_state_next = FADE_DOWN;
            end else begin
              bright_next = bright_reg + 8'h01;
            end
          end else begin
            step_next = step_reg + 10'h001;
          end
        end
        FADE_DOWN: begin
          if (step_reg == 10'(FADE_STEP_CYCLES - 1)) begin
            step_next = '0;
            if (bright_reg == DUTY_OFF) begin
              fade_state_next = FADE_UP;
            end else begin
              bright_next = bright_reg - 8'h01;
            end
          end else begin
            step_next = step_reg + 10'h001;
          end
        end
        default: begin
          fade_state_next = FADE_OFF;
          bright_next     = DUTY_OFF;
          step_next       = '0;
        end
      endcase
    end
  end

  // Fade registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fade_state_reg <= FADE_OFF;
      bright_reg     <= DUTY_OFF;
      step_reg       <= '0;
    end else begin
      fade_state_reg <= fade_state_next;
      bright_reg     <= bright_next;
      step_reg       <= step_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse-width generators, each output registered inside
  pwm_gen u_disk_pwm (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .sync_clear (!global_reset_n),
    .duty    (disk_duty_reg),
    .pwm_out (disk_activity_pwm)
  );

  pwm_gen u_fade_pwm (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .sync_clear (!global_reset_n),
    .duty    (bright_reg),
    .pwm_out (suspend_fade_pwm)
  );

  // One fixed function per pin, all straight from flops
  assign heartbeat_out            = hb_reg;
  assign link_power_state_code    = psc_reg;
  assign legacy_suspend_out       = sus_reg;
  assign legacy_connected_out     = lcon_reg;
  assign superspeed_connected_out = scon_reg;
  assign push_button_state        = btn_reg;
  assign ref_freq_mhz             = freq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_code_u0_match: assert property (global_reset_n && superspeed_connected &&
    usb3_link_state == LINK_U0 |=> link_power_state_code == 2'h3) else $error("code not 11 in U0");
  a_code_default: assert property (!superspeed_connected |=>
    link_power_state_code == 2'h0) else $error("code not 00 without link");
  a_reset_quiet: assert property (!global_reset_n |=> !heartbeat_out &&
    !legacy_suspend_out && !legacy_connected_out && !superspeed_connected_out &&
    link_power_state_code == 2'h0 && bright_reg == 8'h00) else $error("activity during reset");
  a_reset_defaults: assert property (!global_reset_n |=> hb_cnt_reg == 32'h0000_0000 &&
    fade_state_reg == FADE_OFF && disk_duty_reg == 8'h00) else $error("register not default");
  a_button_sample: assert property (global_reset_n |=>
    push_button_state == $past(push_button_in)) else $error("button not sampled");
  a_strap_decode: assert property (!global_reset_n && ref_freq_strap == 2'h1 |=>
    ref_freq_mhz == 6'h19) else $error("strap decode wrong");
  a_strap_hold: assert property (global_reset_n |=> $stable(ref_freq_mhz))
    else $error("frequency changed after reset");
  a_fade_only_sus: assert property (!suspend_cond |=> fade_state_reg == FADE_OFF)
    else $error("fading without suspend");
  a_fade_moves: assert property (suspend_cond && fade_state_reg != FADE_OFF &&
    step_reg == 10'h000 ##1 suspend_cond [*8] |-> ##[1:1000] (step_reg == 10'h000))
    else $error("fade stalled");
  a_conn_follow: assert property (global_reset_n |=> legacy_connected_out ==
    $past(legacy_connected) && superspeed_connected_out == $past(superspeed_connected))
    else $error("connected indicator wrong");
  a_heartbeat_toggle: assert property (global_reset_n && fw_running &&
    hb_cnt_reg == 32'(HEARTBEAT_HALF_CYCLES - 1) |=> heartbeat_out != $past(heartbeat_out))
    else $error("heartbeat did not toggle");
  a_disk_duty: assert property (global_reset_n && storage_busy |=>
    disk_duty_reg == 8'hC0) else $error("disk duty wrong");

  c_u0_code: cover property (link_power_state_code == 2'h3);
  c_fade_down: cover property (fade_state_reg == FADE_UP ##1 fade_state_reg == FADE_DOWN);
  c_button: cover property ($rose(push_button_state));
  c_heartbeat: cover property ($rose(heartbeat_out));

endmodule : bridge_status_led_and_strap

/* tb/board_model.sv */
`timescale 1ns/1ps
module board_model #(
  parameter int HOLD_CYCLES = 16  // Scaled stand-in for the board reset hold
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Requests from the bench
  input  wire logic       reset_req,
  input  wire logic [1:0] strap_sel,
  input  wire logic       button_pressed,
  // Board pins
  output logic            global_reset_n,
  output logic [1:0]      ref_freq_strap,
  output logic            push_button_in
);
  int hold_cnt;  // Reset cycles still owed

  ////////////////////////////////////////////////////////////////////////////
  // Reset source: never releases early, even if the bench asks twice
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_cnt       <= HOLD_CYCLES;
      global_reset_n <= 1'h0;
    end else if (reset_req) begin
      hold_cnt       <= HOLD_CYCLES;
      global_reset_n <= 1'h0;
    end else if (hold_cnt > 1) begin
      hold_cnt       <= hold_cnt - 1;
    end else begin
      hold_cnt       <= 0;
      global_reset_n <= 1'h1;
    end
  end

  // Straps wired to the chosen reference, button a plain switch
  assign ref_freq_strap = strap_sel;
  assign push_button_in = button_pressed;
endmodule : board_model

/* tb/bridge_status_led_and_strap_tb.sv */
`timescale 1ns/1ps
module bridge_status_led_and_strap_tb;
  import bridge_led_pkg::*;
  localparam int HB = 8;          // Short heartbeat half period for simulation
  logic       sys_clk = 1'h0;     // Core clock
  logic       rst = 1'h1;         // Async reset
  logic       reset_req = 1'h0;   // Ask board for a global reset
  logic [1:0] strap_sel = 2'h0;   // Chosen reference
  logic       button = 1'h0;      // Board button
  logic       fw_running = 1'h0;  // Status inputs
  logic       storage_busy = 1'h0;
  logic       ss_conn = 1'h0;
  logic       leg_conn = 1'h0;
  logic       leg_susp = 1'h0;
  logic [1:0] link_state = 2'h0;
  logic       global_reset_n, push_button_in, push_button_state, heartbeat_out;
  logic       legacy_suspend_out, legacy_connected_out, superspeed_connected_out;
  logic       disk_activity_pwm, suspend_fade_pwm;
  logic [1:0] ref_freq_strap, link_power_state_code;
  logic [5:0] ref_freq_mhz;
  int         miscompares = 0;
  int         n_checks = 0;
  int         seed = 32'he086;
  int         hi;

  always #2 sys_clk = ~sys_clk;

  board_model u_board_model (.sys_clk(sys_clk), .rst(rst), .reset_req(reset_req),
    .strap_sel(strap_sel), .button_pressed(button), .global_reset_n(global_reset_n),
    .ref_freq_strap(ref_freq_strap), .push_button_in(push_button_in));

  bridge_status_led_and_strap #(.HEARTBEAT_HALF_CYCLES(HB)) u_bridge_status_led_and_strap (
    .sys_clk(sys_clk), .rst(rst), .global_reset_n(global_reset_n),
    .ref_freq_strap(ref_freq_strap), .fw_running(fw_running), .storage_busy(storage_busy),
    .superspeed_connected(ss_conn), .legacy_connected(leg_conn), .legacy_suspend(leg_susp),
    .usb3_link_state(link_state), .push_button_in(push_button_in),
    .push_button_state(push_button_state), .heartbeat_out(heartbeat_out),
    .link_power_state_code(link_power_state_code), .legacy_suspend_out(legacy_suspend_out),
    .legacy_connected_out(legacy_connected_out),
    .superspeed_connected_out(superspeed_connected_out),
    .disk_activity_pwm(disk_activity_pwm), .suspend_fade_pwm(suspend_fade_pwm),
    .ref_freq_mhz(ref_freq_mhz));

  ////////////////////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [1:0] exp_code(input logic ss, input logic [1:0] st);
    if (!ss) begin
      return PSC_U3;  // No SuperSpeed link reads as the default code
    end
    return 2'h3 - st;
  endfunction : exp_code

  function automatic logic [5:0] exp_freq(input logic [1:0] s);
    logic [5:0] tbl[4];
    tbl = '{FREQ_20_MHZ, FREQ_25_MHZ, FREQ_30_MHZ, FREQ_40_MHZ};
    return tbl[s];
  endfunction : exp_freq

  task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
    n_checks++;
    if (exp !== got) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Count high cycles of one pulse-width pin over n cycles
  task automatic count_high(input bit fade, input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(negedge sys_clk);
      cnt += fade ? int'(suspend_fade_pwm) : int'(disk_activity_pwm);
    end
  endtask : count_high

  task automatic wait_release;
    int k;
    k = 0;
    while (global_reset_n !== 1'h1 && k < 200) begin
      @(negedge sys_clk);
      k++;
    end
    // A reset that never lets go is a mismatch and ends the run
    if (global_reset_n !== 1'h1) begin
      miscompares++;
      $display("BAD global_reset_n expected 1 seen %b", global_reset_n);
      stop_test();
    end
  endtask : wait_release

  task automatic stop_test;
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under 10k cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (9) @(posedge sys_clk);
    @(negedge sys_clk);
    check("rst_outs", 9'h000, {heartbeat_out, link_power_state_code, legacy_suspend_out,
      legacy_connected_out, superspeed_connected_out, disk_activity_pwm,
      suspend_fade_pwm, push_button_state});
    check("rst_freq", 9'(FREQ_20_MHZ), 9'(ref_freq_mhz));
    @(posedge sys_clk);
    rst <= 1'h0;
    // Every strap code, with all status lines busy during global reset
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      {reset_req, fw_running, storage_busy, ss_conn, leg_conn, leg_susp, button} <= 7'h7F;
      strap_sel  <= 2'(s);
      link_state <= LINK_U0;
      @(posedge sys_clk);
      reset_req <= 1'h0;
      repeat (6) @(negedge sys_clk);
      check("busy_in_reset", 9'h000, {heartbeat_out, link_power_state_code,
        legacy_suspend_out, legacy_connected_out, superspeed_connected_out,
        disk_activity_pwm, suspend_fade_pwm, push_button_state});
      wait_release();
      @(posedge sys_clk);
      strap_sel <= ~2'(s);  // Late strap change must not be taken
      repeat (3) @(negedge sys_clk);
      check("ref_freq", 9'(exp_freq(2'(s))), 9'(ref_freq_mhz));
    end
    // Random status traffic, code, connected, suspend and button outputs one cycle behind their inputs
    for (int i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      {fw_running, storage_busy, ss_conn, leg_conn, leg_susp, button, link_state} <=
        8'($random(seed));
      @(negedge sys_clk);
      if (i > 0) begin
        @(negedge sys_clk);
        check("code", 9'(exp_code(ss_conn, link_state)), 9'(link_power_state_code));
        check("conn", 9'({leg_conn, ss_conn, leg_susp}), 9'({legacy_connected_out,
          superspeed_connected_out, legacy_suspend_out}));
        check("button", 9'(button), 9'(push_button_state));
      end
    end
    // Heartbeat runs only with firmware alive
    @(posedge sys_clk);
    {fw_running, storage_busy, ss_conn, leg_conn, leg_susp} <= 5'h10;
    @(negedge sys_clk);
    hi = 0;
    for (int i = 0; i < 20 * HB; i++) begin
      logic prev;
      prev = heartbeat_out;
      @(negedge sys_clk);
      hi += int'(prev !== heartbeat_out);
    end
    check("hb_toggles", 9'h014, 9'(hi));
    @(posedge sys_clk);
    fw_running <= 1'h0;
    @(negedge sys_clk);
    hi = 0;
    for (int i = 0; i < 40; i++) begin
      logic prev;
      prev = heartbeat_out;
      @(negedge sys_clk);
      hi += int'(prev !== heartbeat_out);
    end
    check("hb_idle", 9'h000, 9'(hi));
    // Disk activity duty, then idle
    for (int b = 1; b >= 0; b--) begin
      @(posedge sys_clk);
      storage_busy <= 1'(b);
      repeat (4) @(negedge sys_clk);
      count_high(1'b0, 256, hi);
      check("disk_duty", b ? 9'(DISK_ACTIVE_DUTY) : 9'h000, 9'(hi));
    end
    // Fade through legacy suspend, then SuperSpeed U3, then U0
    @(posedge sys_clk);
    leg_susp <= 1'h1;
    repeat (2 * FADE_STEP_CYCLES + 300) @(negedge sys_clk);
    count_high(1'b1, 256, hi);
    check("fade_legacy", 9'h002, 9'(hi));
    @(posedge sys_clk);
    leg_susp <= 1'h0;
    repeat (4) @(negedge sys_clk);
    count_high(1'b1, 256, hi);
    check("fade_off", 9'h000, 9'(hi));
    @(posedge sys_clk);
    ss_conn    <= 1'h1;
    link_state <= LINK_U3;
    repeat (FADE_STEP_CYCLES + 300) @(negedge sys_clk);
    count_high(1'b1, 256, hi);
    check("fade_u3", 9'h001, 9'(hi));
    @(posedge sys_clk);
    link_state <= LINK_U0;
    repeat (4) @(negedge sys_clk);
    count_high(1'b1, 256, hi);
    check("fade_u0", 9'h000, 9'(hi));
    stop_test();
  end
endmodule : bridge_status_led_and_strap_tb
